/* spi_irq_pkg.sv */
// Constants, types and helpers for the serial port and interrupt logic
// How it works
// R1: Capture input bits on serial clock fall
// R2: Launch output bits on serial clock rise
// R3: Chip select fall resets to command state
// R4: Chip select rise aborts, output floats
// R5: Host holds select low through whole transfer
// R6: First byte after reset is command
// R7: Command MSB write, low six bits address
// R8: Back to command state after last bit
// R9: Write bytes MSB first, right justified
// R10: Host spaces write bytes by one microsecond
// R11: Partial write byte never committed
// R12: Drive output from first rise after command
// R13: Snapshot whole register before read shifting
// R14: Host waits one microsecond before read
// R15: Events set flags regardless of enables
// R16: Request low when enabled flag set
// R17: Read of 11h returns and clears flags
// R18: Events during clearing read are retained
// R19: Request held high through status transfer
// R20: Synchronise serial pins before any use
`default_nettype none
package spi_irq_pkg;
    // ==========================================================
    // Register map and field layout
    localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h0f;
    localparam logic [5:0] ADDR_FLAGS = 6'h10;
    localparam logic [5:0] ADDR_FLAGS_CLR = 6'h11;
    localparam int CMD_WRITE_BIT = 7;
    localparam int ADDR_MSB = 5;
    localparam int DATA_W = 24;
    localparam int FLAG_W = 16;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [1:0] BYTES_FLAG = 2'h2;
    localparam logic [1:0] BYTES_WIDE = 2'h3;
    localparam logic [1:0] FIRST_BYTE = 2'h0;
    // Serial pins idle high until the host drives them
    localparam logic [2:0] PIN_IDLE = 3'h7;

    // ==========================================================
    // Port states, Gray along command to write, read two bits from command
    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WR = 2'b01,
        ST_RD = 2'b11
    } port_state_t;

    // ==========================================================
    // Decoding used by both directions
    function automatic logic [1:0] reg_bytes(input logic [5:0] addr);
        if (addr == ADDR_IRQ_ENABLE || addr == ADDR_FLAGS ||
                addr == ADDR_FLAGS_CLR) begin
            return BYTES_FLAG;
        end
        return BYTES_WIDE;
    endfunction : reg_bytes

    // Left align a right-justified value for MSB-first shifting
    function automatic logic [DATA_W-1:0] align_out(
            input logic [DATA_W-1:0] val, input logic [1:0] nbytes);
        case (nbytes)
            2'h1: return {val[7:0], 16'h0000};
            2'h2: return {val[15:0], 8'h00};
            default: return val;
        endcase
    endfunction : align_out
endpackage : spi_irq_pkg
`default_nettype wire

/* pin_sync.sv */
// Two-stage synchroniser for the serial pins
`default_nettype none
module pin_sync
    import spi_irq_pkg::*;
#(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_t;

    sync_t sync_ff;
    sync_t nxt_sync;

    // ==========================================================
    // Stage one feeds only stage two
    always_comb begin
        nxt_sync.stage1 = pin_in;
        nxt_sync.stage2 = sync_ff.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_ff <= {RST_VAL, RST_VAL};
        end else begin
            sync_ff <= nxt_sync; // [R20]
        end
    end

    assign pin_out = sync_ff.stage2;
endmodule : pin_sync
`default_nettype wire

/* irq_flags.sv */
// Interrupt flags, enables and request drive
`default_nettype none
module irq_flags
    import spi_irq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [FLAG_W-1:0] events,
    input wire logic en_wr,
    input wire logic en_hi,
    input wire logic [7:0] en_byte,
    input wire logic clr_stb,
    input wire logic hold_end,
    output logic [FLAG_W-1:0] flags,
    output logic [FLAG_W-1:0] enable,
    output logic irq_oe
);
    typedef struct packed {
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] enable;
        logic hold;
        logic irq_oe;
    } irq_t;

    irq_t irq_ff;
    irq_t nxt_irq;

    // ==========================================================
    // Flag update, set wins over the clear
    always_comb begin
        nxt_irq = irq_ff;
        nxt_irq.flags = (irq_ff.flags & ~{FLAG_W{clr_stb}}) | events;
        if (en_wr && en_hi) begin
            nxt_irq.enable[15:8] = en_byte;
        end else if (en_wr) begin
            nxt_irq.enable[7:0] = en_byte;
        end
        if (clr_stb) begin
            nxt_irq.hold = 1'b1; // [R19]
        end else if (hold_end) begin
            nxt_irq.hold = 1'b0;
        end
        // Open drain pulls low only while an enabled flag is pending
        nxt_irq.irq_oe = |(nxt_irq.flags & nxt_irq.enable) &&
            !nxt_irq.hold; // [R16] [R18]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_ff <= '0;
        end else begin
            irq_ff <= nxt_irq; // [R15] [R17]
        end
    end

    assign flags = irq_ff.flags;
    assign enable = irq_ff.enable;
    assign irq_oe = irq_ff.irq_oe;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_flag_set: assert property ( // [R15]
        |events |=> (irq_ff.flags & $past(events)) == $past(events))
        else $error("event did not set its flag");
    a_irq_gate: assert property ( // [R16]
        irq_oe == (|(flags & enable) && !irq_ff.hold))
        else $error("request does not follow enabled flags");
    a_clear_release: assert property ( // [R17]
        clr_stb |=> !irq_oe && irq_ff.hold)
        else $error("clearing read did not release request");
    a_clear_flags: assert property ( // [R17]
        clr_stb |=> flags == $past(events))
        else $error("clearing read left old flags set");
    a_event_kept: assert property ( // [R18]
        clr_stb && |events |=>
        (irq_ff.flags & $past(events)) == $past(events))
        else $error("event lost during clearing read");
    a_hold_high: assert property ( // [R19]
        irq_ff.hold && !hold_end |=> !irq_oe)
        else $error("request low during status transfer");
    c_clear_with_event: cover property (clr_stb && |events);
endmodule : irq_flags
`default_nettype wire

/* spi_irq_port.sv */
// Serial slave port with command decode and interrupt request
`default_nettype none
module spi_irq_port
    import spi_irq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic din,
    input wire logic cs_n,
    input wire logic [FLAG_W-1:0] irq_events,
    input wire logic [DATA_W-1:0] ext_rd_data,
    output logic dout,
    output logic dout_oe,
    output logic irq_n_out,
    output logic irq_n_oe,
    output logic [5:0] reg_addr,
    output logic wr_stb,
    output logic [1:0] wr_idx,
    output logic [7:0] wr_byte
);
    typedef struct packed {
        port_state_t st;
        logic sclk_prev;
        logic cs_prev;
        logic [3:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [1:0] nbytes;
        logic [5:0] addr;
        logic [7:0] in_byte;
        logic [DATA_W-1:0] out_sh;
        logic load_pend;
        logic dout;
        logic dout_oe;
        logic wr_stb;
        logic [1:0] wr_idx;
        logic [7:0] wr_byte;
        logic flag_clr;
        logic hold_end;
        logic irq_lvl;
    } port_t;

    port_t port_ff;
    port_t nxt_port;

    logic [2:0] pins_s;
    logic sclk_s;
    logic din_s;
    logic cs_n_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic byte_done;
    logic last_byte;
    logic [7:0] cmd_byte;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enable;
    logic irq_oe;
    logic [DATA_W-1:0] rd_value;
    logic en_wr;

    // ==========================================================
    // Pin synchronisers
    pin_sync #(
        .W(3),
        .RST_VAL(PIN_IDLE)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in({sclk, din, cs_n}),
        .pin_out(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign din_s = pins_s[1];
    assign cs_n_s = pins_s[0];

    // ==========================================================
    // Edge detection on synchronised levels only
    assign sclk_rise = !port_ff.sclk_prev && sclk_s; // [R20]
    assign sclk_fall = port_ff.sclk_prev && !sclk_s; // [R20]
    assign cs_fall = port_ff.cs_prev && !cs_n_s;
    assign byte_done = sclk_fall && !cs_n_s && !cs_fall &&
        port_ff.bit_cnt == LAST_BIT;
    assign last_byte = port_ff.byte_cnt == port_ff.nbytes - 2'h1;
    assign cmd_byte = {port_ff.in_byte[6:0], din_s};

    // ==========================================================
    // Interrupt flags and enables
    assign en_wr = port_ff.wr_stb && port_ff.addr == ADDR_IRQ_ENABLE;

    irq_flags u_irq (
        .clk_sys(clk_sys),
        .rst(rst),
        .events(irq_events),
        .en_wr(en_wr),
        .en_hi(port_ff.wr_idx == BYTES_WIDE - BYTES_FLAG),
        .en_byte(port_ff.wr_byte),
        .clr_stb(port_ff.flag_clr),
        .hold_end(port_ff.hold_end),
        .flags(flags),
        .enable(enable),
        .irq_oe(irq_oe)
    );

    // ==========================================================
    // Read source selection
    always_comb begin
        case (port_ff.addr)
            ADDR_IRQ_ENABLE: rd_value = {8'h00, enable};
            ADDR_FLAGS: rd_value = {8'h00, flags};
            ADDR_FLAGS_CLR: rd_value = {8'h00, flags};
            default: rd_value = ext_rd_data;
        endcase
    end

    // ==========================================================
    // Port sequencing
    always_comb begin
        nxt_port = port_ff;
        nxt_port.sclk_prev = sclk_s;
        nxt_port.cs_prev = cs_n_s;
        nxt_port.wr_stb = 1'b0;
        nxt_port.flag_clr = 1'b0;
        nxt_port.hold_end = 1'b0;
        nxt_port.load_pend = 1'b0;
        nxt_port.irq_lvl = 1'b0;
        if (port_ff.load_pend) begin
            // Whole value caught before the first bit leaves
            nxt_port.out_sh = align_out(rd_value,
                port_ff.nbytes); // [R13]
        end
        if (cs_fall) begin
            nxt_port.st = ST_CMD; // [R3] [R6]
            nxt_port.bit_cnt = '0;
            nxt_port.byte_cnt = '0;
            nxt_port.dout_oe = 1'b0;
        end else if (cs_n_s) begin
            // Abort drops any partial byte, nothing is committed
            nxt_port.st = ST_CMD; // [R4] [R11]
            nxt_port.bit_cnt = '0;
            nxt_port.byte_cnt = '0;
            nxt_port.dout_oe = 1'b0;
            nxt_port.hold_end = 1'b1;
        end else begin
            if (sclk_rise && port_ff.st == ST_RD) begin
                nxt_port.dout = port_ff.out_sh[DATA_W-1]; // [R2]
                nxt_port.out_sh = {port_ff.out_sh[DATA_W-2:0], 1'b0};
                nxt_port.dout_oe = 1'b1; // [R12]
            end
            if (sclk_fall) begin
                nxt_port.in_byte = cmd_byte; // [R1]
                nxt_port.bit_cnt = port_ff.bit_cnt + 4'h1;
            end
            if (byte_done) begin
                nxt_port.bit_cnt = '0;
                case (port_ff.st)
                    ST_CMD: begin
                        nxt_port.addr = cmd_byte[ADDR_MSB:0]; // [R7]
                        nxt_port.nbytes = reg_bytes(cmd_byte[ADDR_MSB:0]);
                        nxt_port.byte_cnt = '0;
                        if (cmd_byte[CMD_WRITE_BIT]) begin
                            nxt_port.st = ST_WR; // [R7]
                        end else begin
                            nxt_port.st = ST_RD;
                            nxt_port.load_pend = 1'b1; // [R13]
                            nxt_port.flag_clr = cmd_byte[ADDR_MSB:0] ==
                                ADDR_FLAGS_CLR; // [R17] [R18]
                        end
                    end
                    ST_WR: begin
                        // First byte lands on the top byte of wide registers, on byte 1 of short ones
                        nxt_port.wr_stb = 1'b1; // [R9] [R11]
                        nxt_port.wr_byte = cmd_byte;
                        nxt_port.wr_idx = port_ff.byte_cnt
                            + (BYTES_WIDE - port_ff.nbytes); // [R9]
                        if (last_byte) begin
                            nxt_port.st = ST_CMD; // [R8]
                        end else begin
                            nxt_port.byte_cnt = port_ff.byte_cnt + 2'h1;
                        end
                    end
                    ST_RD: begin
                        if (last_byte) begin
                            nxt_port.st = ST_CMD; // [R8]
                            nxt_port.dout_oe = 1'b0; // [R12]
                            nxt_port.hold_end = 1'b1; // [R19]
                        end else begin
                            nxt_port.byte_cnt = port_ff.byte_cnt + 2'h1;
                        end
                    end
                    default: begin
                        nxt_port.st = ST_CMD;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_ff <= '0;
            port_ff.sclk_prev <= 1'b1;
            port_ff.cs_prev <= 1'b1;
        end else begin
            port_ff <= nxt_port;
        end
    end

    assign dout = port_ff.dout;
    assign dout_oe = port_ff.dout_oe;
    assign irq_n_out = port_ff.irq_lvl;
    assign irq_n_oe = irq_oe;
    assign reg_addr = port_ff.addr;
    assign wr_stb = port_ff.wr_stb;
    assign wr_idx = port_ff.wr_idx;
    assign wr_byte = port_ff.wr_byte;

    // ==========================================================
    // Checks on framing and decode
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_pin_delay: assert property ( // [R20]
        pins_s == $past({sclk, din, cs_n}, 2))
        else $error("serial pins not passed through two stages");
    a_capture_fall: assert property ( // [R1]
        $changed(port_ff.in_byte) |-> $past(sclk_fall))
        else $error("input bit taken off a falling edge");
    a_bit_count: assert property ( // [R1]
        sclk_fall && !cs_n_s && !cs_fall && !byte_done |=>
        port_ff.bit_cnt == $past(port_ff.bit_cnt) + 4'h1)
        else $error("falling edge not counted");
    a_launch_rise: assert property ( // [R2]
        $changed(dout) |-> $past(sclk_rise))
        else $error("output bit changed off a rising edge");
    a_cs_fall_reset: assert property ( // [R3]
        cs_fall |=> port_ff.st == ST_CMD && port_ff.bit_cnt == 4'h0)
        else $error("select fall did not reset port");
    a_cs_high_float: assert property (cs_n_s |=> !dout_oe) // [R4]
        else $error("output driven with select high");
    a_idle_cmd: assert property ( // [R4]
        cs_n_s |=> port_ff.st == ST_CMD && port_ff.bit_cnt == 4'h0)
        else $error("port left command state with select high");
    a_select_cmd: assert property ( // [R6]
        cs_fall |=> port_ff.byte_cnt == 2'h0 && !dout_oe)
        else $error("first byte after select fall not a command");
    a_cmd_decode: assert property ( // [R7]
        byte_done && port_ff.st == ST_CMD |=>
        port_ff.st == ($past(cmd_byte[CMD_WRITE_BIT]) ? ST_WR : ST_RD)
        && port_ff.addr == $past(cmd_byte[ADDR_MSB:0]))
        else $error("command byte decoded wrongly");
    a_addr_hold: assert property ( // [R7]
        !(byte_done && port_ff.st == ST_CMD) |=> $stable(reg_addr))
        else $error("address changed outside a command byte");
    a_read_end: assert property ( // [R8]
        byte_done && port_ff.st == ST_RD && last_byte |=>
        port_ff.st == ST_CMD && !dout_oe)
        else $error("read did not end in command state");
    a_write_end: assert property ( // [R8]
        byte_done && port_ff.st == ST_WR && last_byte |=>
        port_ff.st == ST_CMD)
        else $error("write did not end in command state");

    // ==========================================================
    // Checks on data
    a_short_idx: assert property ( // [R9]
        wr_stb && port_ff.nbytes == BYTES_FLAG |-> wr_idx != FIRST_BYTE)
        else $error("short register written at its top byte");
    a_write_whole: assert property ( // [R11]
        wr_stb |-> $past(sclk_fall) && $past(port_ff.st) == ST_WR &&
        $past(!cs_n_s))
        else $error("partial byte committed");
    a_abort_nowrite: assert property (cs_n_s |=> !wr_stb) // [R11]
        else $error("write committed after abort");
    a_drive_start: assert property ( // [R12]
        $rose(dout_oe) |-> $past(sclk_rise) &&
        $past(port_ff.byte_cnt) == 2'h0 && $past(port_ff.bit_cnt) == 4'h0)
        else $error("output driven before first data rise");
    a_oe_reads_only: assert property ( // [R12]
        dout_oe |-> port_ff.st == ST_RD)
        else $error("output driven outside a read");
    a_snapshot: assert property ( // [R13]
        port_ff.load_pend |=> port_ff.out_sh ==
        align_out($past(rd_value), $past(port_ff.nbytes)))
        else $error("read value not snapshotted");
    a_load_read: assert property ( // [R13]
        port_ff.load_pend |-> port_ff.st == ST_RD && !dout_oe)
        else $error("snapshot taken outside a read start");

    // ==========================================================
    // Checks on the clearing read
    // Clear in the snapshot cycle so no event slips between the two
    a_clear_snap: assert property ( // [R18]
        port_ff.flag_clr |-> port_ff.load_pend &&
        port_ff.addr == ADDR_FLAGS_CLR)
        else $error("flags cleared outside the snapshot");
    a_clear_read: assert property ( // [R17]
        port_ff.load_pend && port_ff.addr == ADDR_FLAGS_CLR |->
        port_ff.flag_clr)
        else $error("clearing read left flags set");

    c_write: cover property (wr_stb && last_byte);
    c_read: cover property (byte_done && port_ff.st == ST_RD);
    c_abort: cover property (cs_n_s && port_ff.st == ST_RD);
    c_clear: cover property (port_ff.flag_clr);
endmodule : spi_irq_port
`default_nettype wire

/* spi_host.sv */
// Behavioural host processor driving the serial link
`default_nettype none
module spi_host (
    input wire logic clk_sys,
    input wire logic miso,
    output logic sclk,
    output logic din,
    output logic cs_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] rx_data;
    event rx_ev;

    initial begin
        sclk = 1'b1;
        din = 1'b1;
        cs_n = 1'b1;
        rx_data = '0;
    end

    // ==========================================================
    // Link clock half period, 40 ns
    task automatic half();
        repeat (10) @(negedge clk_sys);
    endtask : half

    // Hold keeps select low so the next command follows directly
    task automatic xfer(input logic [31:0] tx, input int nbits,
            input bit hold, input bit rd);
        logic [31:0] rx;
        rx = '0;
        if (cs_n) begin
            // Select stays high a whole half period between frames
            half();
            cs_n = 1'b0;
            half();
        end
        for (int i = nbits - 1; i >= 0; i--) begin
            if (!rd && i % 8 == 7 && i < nbits - 16) begin
                repeat (250) @(negedge clk_sys);
            end
            din = tx[i];
            half();
            rx = {rx[30:0], miso};
            sclk = 1'b0;
            half();
            sclk = 1'b1;
        end
        if (!hold) begin
            half();
            cs_n = 1'b1;
            // Released line must not keep its last value
            din = ~din;
        end
        if (!rd && nbits > 8) begin
            repeat (260) @(negedge clk_sys);
        end
        if (rd) begin
            rx_data = rx & ((32'h1 << (nbits - 8)) - 32'h1);
            ->rx_ev;
        end
    endtask : xfer
endmodule : spi_host
`default_nettype wire

/* tb_serial_port_and_irq_logic.sv */
// Self-checking bench for the serial port and interrupt flags
`default_nettype none
module tb_serial_port_and_irq_logic
    import spi_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst, sclk, din, cs_n, dout, dout_oe;
    logic irq_n_out, irq_n_oe, wr_stb, miso, irq_line;
    logic [FLAG_W-1:0] irq_events;
    logic [DATA_W-1:0] ext_rd_data;
    logic [5:0] reg_addr;
    logic [1:0] wr_idx;
    logic [7:0] wr_byte;
    logic [15:0] seed;
    logic [15:0] en_val;
    logic [23:0] xval;
    int n_fail, n_compared;
    logic [9:0] wq[$];
    logic [31:0] rq[$];

    // Floating output shows as unknown so a missing drive fails
    assign miso = dout_oe ? dout : 1'bz;
    // Open-drain request line with a pull-up
    assign irq_line = irq_n_oe ? irq_n_out : 1'b1;

    spi_irq_port uut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
        .din(din), .cs_n(cs_n), .irq_events(irq_events),
        .ext_rd_data(ext_rd_data), .dout(dout), .dout_oe(dout_oe),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
        .reg_addr(reg_addr), .wr_stb(wr_stb), .wr_idx(wr_idx),
        .wr_byte(wr_byte));
    spi_host host (.clk_sys(clk_sys), .miso(miso), .sclk(sclk),
        .din(din), .cs_n(cs_n));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic bad(input string m);
        n_fail++;
        $display("ERROR at %0t: %s", $time, m);
    endtask : bad

    task automatic cmp_bit(input logic got, input logic exp, string m);
        n_compared++;
        if (got !== exp) bad(m);
    endtask : cmp_bit

    task automatic cmp_val(input logic [31:0] got, exp, string m);
        n_compared++;
        if (got !== exp) bad(m);
    endtask : cmp_val

    task automatic stop_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic pulse(input logic [15:0] e);
        @(negedge clk_sys);
        irq_events = e;
        @(negedge clk_sys);
        irq_events = '0;
    endtask : pulse

    // One whole access; expectations queued before the frame starts
    task automatic access(input bit wr, input logic [5:0] a,
            input logic [23:0] v, input bit hold);
        int nb;
        logic [7:0] cmd;
        nb = (a == ADDR_IRQ_ENABLE || a == ADDR_FLAGS ||
              a == ADDR_FLAGS_CLR) ? 2 : 3;
        cmd = {wr, 1'b0, a};
        if (wr) begin
            for (int k = 0; k < nb; k++) begin
                wq.push_back({2'(3 - nb + k), v[8*(nb-1-k) +: 8]});
            end
        end else begin
            rq.push_back(32'(v));
            seed = lfsr(seed);
            v = {seed, seed[7:0]};
        end
        host.xfer(nb == 3 ? {cmd, v} : {8'h00, cmd, v[15:0]},
            8 + 8 * nb, hold, !wr);
        cmp_val(32'(reg_addr), 32'(a), "address");
    endtask : access

    // ==========================================================
    // Result watchers
    always @(negedge clk_sys) begin
        if (!rst && wr_stb === 1'b1) begin
            if (wq.size() == 0) bad("unexpected write strobe");
            else cmp_val(32'({wr_idx, wr_byte}),
                32'(wq.pop_front()), "write byte");
        end
    end

    always @(host.rx_ev) begin
        if (rq.size() == 0) bad("unexpected read");
        else cmp_val(host.rx_data, rq.pop_front(), "read data");
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        bad("watchdog expired");
        stop_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        irq_events = '0;
        ext_rd_data = '0;
        seed = 16'h0025;
        n_fail = 0;
        n_compared = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        cmp_bit(irq_line, 1'b1, "request idle");
        cmp_bit(dout_oe, 1'b0, "output idle");
        $display("test reset done");

        seed = lfsr(seed);
        en_val = (seed | 16'h0003) & 16'hfffb;
        access(1, ADDR_IRQ_ENABLE, {8'h00, en_val}, 1);
        access(0, ADDR_IRQ_ENABLE, {8'h00, en_val}, 1);
        access(0, ADDR_FLAGS, 24'h0000_00, 0);
        $display("test enable done");

        seed = lfsr(seed);
        access(1, 6'h05, {seed, 8'h5a}, 0);
        seed = lfsr(seed);
        xval = {seed[7:0], seed};
        ext_rd_data = xval;
        fork
            access(0, 6'h05, xval, 0);
            begin
                repeat (300) @(negedge clk_sys);
                ext_rd_data = ~xval;
            end
        join
        $display("test wide done");

        host.xfer(32'h0000_085a, 12, 0, 0);
        host.xfer(32'h0000_0051, 12, 0, 0);
        repeat (8) @(negedge clk_sys);
        cmp_bit(dout_oe, 1'b0, "abort float");
        host.xfer(32'h0000_0005, 3, 0, 0);
        access(0, ADDR_IRQ_ENABLE, {8'h00, en_val}, 0);
        $display("test abort done");

        pulse(16'h0004);
        repeat (5) @(negedge clk_sys);
        cmp_bit(irq_line, 1'b1, "masked event");
        access(0, ADDR_FLAGS, 24'h0000_04, 0);
        pulse(16'h0001);
        repeat (3) @(negedge clk_sys);
        cmp_bit(irq_line, 1'b0, "request");
        fork
            access(0, ADDR_FLAGS_CLR, 24'h0000_05, 0);
            begin
                repeat (200) @(negedge clk_sys);
                cmp_bit(irq_line, 1'b1, "held");
                pulse(16'h0002);
                repeat (150) @(negedge clk_sys);
                cmp_bit(irq_line, 1'b1, "still held");
            end
        join
        repeat (5) @(negedge clk_sys);
        cmp_bit(irq_line, 1'b0, "pending again");
        access(0, ADDR_FLAGS_CLR, 24'h0000_02, 0);
        repeat (5) @(negedge clk_sys);
        cmp_bit(irq_line, 1'b1, "cleared");
        cmp_val(32'(wq.size() + rq.size()), 32'h0, "left over");
        $display("test interrupt done");
        stop_test();
    end
endmodule : tb_serial_port_and_irq_logic
`default_nettype wire
